/* verilog/cfsd_top.sv */
// Purpose: Start-of-frame delimiter match and byte alignment
// Assumes: Symbols follow a detected synchronisation header
// Notes: Delimiter low symbol arrives first after preamble zeros
`include "cfsd_defines.svh"

module cfsd_top (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sync_hdr_found,
	input wire logic sym_valid,
	input wire logic [3:0] sym_data,
	input wire logic rx_abort,
	input wire logic rx_start_irq_en,
	output logic rx_start_irq,
	output logic byte_aligned,
	output logic rx_busy,
	output logic fb_wr_en,
	output logic [7:0] fb_wr_data
);
	cfsd_oct_if oi ();

	cfsd_pkg::cfsd_state_t state_r;
	cfsd_pkg::cfsd_state_t state_nxt;
	cfsd_pkg::cfsd_octet_t delim_r;
	cfsd_pkg::cfsd_octet_t delim_nxt;
	cfsd_pkg::cfsd_octet_t active_r;
	cfsd_pkg::cfsd_octet_t active_nxt;
	cfsd_pkg::cfsd_octet_t rdata_r;
	cfsd_pkg::cfsd_octet_t rdata_nxt;
	logic [6:0] remain_r;
	logic [6:0] remain_nxt;
	logic irq_r;
	logic irq_nxt;
	logic aligned_r;
	logic aligned_nxt;
	logic fb_en_r;
	logic fb_en_nxt;
	cfsd_pkg::cfsd_octet_t fb_data_r;
	cfsd_pkg::cfsd_octet_t fb_data_nxt;
	logic delim_wr;

	function automatic logic phr_ok(input cfsd_pkg::cfsd_octet_t phr);
		phr_ok = phr[`CFSD_PHR_LEN_MSB:0] != `CFSD_LEN_ZERO;
	endfunction : phr_ok

	// ======================================================
	// Delimiter register
	assign delim_wr = reg_wr_en && (reg_addr == `CFSD_DELIM_OFS);

	always_comb begin
		delim_nxt = delim_r;
		if (delim_wr) begin
			delim_nxt = reg_wdata[`CFSD_DELIM_MSB:`CFSD_DELIM_LSB];
		end
		rdata_nxt = (reg_addr == `CFSD_DELIM_OFS) ? delim_r : 8'h00;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			delim_r <= `CFSD_DELIM_RST;
			rdata_r <= 8'h00;
		end else begin
			delim_r <= delim_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// ======================================================
	// Frame sequencing
	assign oi.sym_valid = sym_valid;
	assign oi.sym = sym_data;
	assign oi.clr = (state_r != cfsd_pkg::CFSD_PHR)
		&& (state_r != cfsd_pkg::CFSD_PAYLOAD);

	always_comb begin
		state_nxt = state_r;
		active_nxt = active_r;
		remain_nxt = remain_r;
		irq_nxt = 1'b0;
		aligned_nxt = aligned_r;
		fb_en_nxt = 1'b0;
		fb_data_nxt = fb_data_r;
		if (rx_abort) begin
			state_nxt = cfsd_pkg::CFSD_IDLE;
			aligned_nxt = 1'b0;
		end else begin
			unique case (state_r)
				cfsd_pkg::CFSD_IDLE: begin
					if (sync_hdr_found) begin
						active_nxt = delim_r;
						state_nxt = cfsd_pkg::CFSD_HUNT_LO;
					end
				end
				cfsd_pkg::CFSD_HUNT_LO: begin
					// Preamble zeros are skipped, hence the advice
					// of a nonzero low nibble
					if (sym_valid && sym_data != `CFSD_PREAMBLE_SYM) begin
						if (sym_data == active_r[`CFSD_LO_MSB:0]) begin
							state_nxt = cfsd_pkg::CFSD_HUNT_HI;
						end else begin
							state_nxt = cfsd_pkg::CFSD_IDLE;
						end
					end
				end
				cfsd_pkg::CFSD_HUNT_HI: begin
					if (sym_valid) begin
						if (sym_data == active_r[7:`CFSD_HI_LSB]) begin
							state_nxt = cfsd_pkg::CFSD_PHR;
							aligned_nxt = 1'b1;
						end else begin
							state_nxt = cfsd_pkg::CFSD_IDLE;
						end
					end
				end
				cfsd_pkg::CFSD_PHR: begin
					if (oi.oct_valid) begin
						if (phr_ok(oi.octet)) begin
							irq_nxt = rx_start_irq_en;
							remain_nxt = oi.octet[`CFSD_PHR_LEN_MSB:0];
							state_nxt = cfsd_pkg::CFSD_PAYLOAD;
						end else begin
							state_nxt = cfsd_pkg::CFSD_IDLE;
							aligned_nxt = 1'b0;
						end
					end
				end
				cfsd_pkg::CFSD_PAYLOAD: begin
					if (oi.oct_valid) begin
						fb_en_nxt = 1'b1;
						fb_data_nxt = oi.octet;
						remain_nxt = remain_r - `CFSD_LEN_ONE;
						if (remain_r == `CFSD_LEN_ONE) begin
							state_nxt = cfsd_pkg::CFSD_IDLE;
							aligned_nxt = 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= cfsd_pkg::CFSD_IDLE;
			active_r <= `CFSD_DELIM_RST;
			remain_r <= 7'h00;
			irq_r <= 1'b0;
			aligned_r <= 1'b0;
			fb_en_r <= 1'b0;
			fb_data_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			active_r <= active_nxt;
			remain_r <= remain_nxt;
			irq_r <= irq_nxt;
			aligned_r <= aligned_nxt;
			fb_en_r <= fb_en_nxt;
			fb_data_r <= fb_data_nxt;
		end
	end

	cfsd_octet_asm u_asm (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.oi(oi.asm)
	);

	assign rx_start_irq = irq_r;
	assign byte_aligned = aligned_r;
	assign rx_busy = state_r != cfsd_pkg::CFSD_IDLE;
	assign fb_wr_en = fb_en_r;
	assign fb_wr_data = fb_data_r;

	// ======================================================
	// Checks
	a_delim_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		delim_wr |=> delim_r == $past(reg_wdata))
		else $error("Delimiter write not stored");

	a_delim_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!delim_wr |=> $stable(delim_r))
		else $error("Delimiter changed without write");

	a_active_frozen: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		(state_r != cfsd_pkg::CFSD_IDLE)
		&& ($past(state_r) != cfsd_pkg::CFSD_IDLE)
		|-> $stable(active_r))
		else $error("Active delimiter changed mid frame");

	a_align_match: assert property (@(posedge core_clk) disable iff (!rst_b)
		(state_r == cfsd_pkg::CFSD_HUNT_HI) && sym_valid && !rx_abort
		&& (sym_data == active_r[7:4]) |=> byte_aligned)
		else $error("Matching delimiter not aligned");

	a_mismatch_drop: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		(state_r == cfsd_pkg::CFSD_HUNT_HI) && sym_valid
		&& (sym_data != active_r[7:4])
		|=> (state_r == cfsd_pkg::CFSD_IDLE) && !byte_aligned)
		else $error("Foreign delimiter not ignored");

	a_fb_payload: assert property (@(posedge core_clk) disable iff (!rst_b)
		fb_wr_en |-> $past(state_r) == cfsd_pkg::CFSD_PAYLOAD)
		else $error("Buffer written outside payload");

	a_irq_cause: assert property (@(posedge core_clk) disable iff (!rst_b)
		rx_start_irq |-> $past(rx_start_irq_en)
		&& ($past(state_r) == cfsd_pkg::CFSD_PHR)
		&& (state_r == cfsd_pkg::CFSD_PAYLOAD))
		else $error("Receive start without valid header");

	a_irq_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
		rx_start_irq |=> !rx_start_irq)
		else $error("Receive start longer than one cycle");

	c_frame_ok: cover property (@(posedge core_clk) disable iff (!rst_b)
		rx_start_irq ##[1:300] fb_wr_en);
	c_foreign: cover property (@(posedge core_clk) disable iff (!rst_b)
		(state_r == cfsd_pkg::CFSD_HUNT_HI) ##1
		(state_r == cfsd_pkg::CFSD_IDLE));
	c_new_delim: cover property (@(posedge core_clk) disable iff (!rst_b)
		delim_wr && (reg_wdata != 8'ha7) ##[1:300] byte_aligned);
endmodule : cfsd_top

/* include/cfsd_defines.svh */
// Purpose: Constants of the configurable frame delimiter detector
// Assumes: Included by its bare name
// Notes: Offsets, field positions, reset values and symbol and length constants
`ifndef CFSD_DEFINES_SVH
`define CFSD_DEFINES_SVH

// ==========================================================
// Register map
`define CFSD_DELIM_OFS 8'h0b
`define CFSD_DELIM_RST 8'ha7
`define CFSD_DELIM_MSB 7
`define CFSD_DELIM_LSB 0

// ==========================================================
// Symbol and header fields
`define CFSD_LO_MSB 3
`define CFSD_HI_LSB 4
`define CFSD_PHR_LEN_MSB 6
`define CFSD_PREAMBLE_SYM 4'h0
`define CFSD_LEN_ZERO 7'h00
`define CFSD_LEN_ONE 7'h01

`endif

/* include/cfsd_pkg.sv */
// Purpose: Shared types of the frame delimiter detector
// Assumes: Nothing
// Notes: Constants live in cfsd_defines.svh
package cfsd_pkg;
	typedef enum logic [2:0] {
		CFSD_IDLE,
		CFSD_HUNT_LO,
		CFSD_HUNT_HI,
		CFSD_PHR,
		CFSD_PAYLOAD
	} cfsd_state_t;

	typedef logic [7:0] cfsd_octet_t;
	typedef logic [3:0] cfsd_sym_t;
endpackage : cfsd_pkg

/* include/cfsd_oct_if.sv */
// Purpose: Symbol-to-octet link between detector and assembler
// Assumes: Single clock domain
// Notes: The detector clears the assembler at byte alignment
interface cfsd_oct_if;
	logic sym_valid;
	cfsd_pkg::cfsd_sym_t sym;
	logic clr;
	logic oct_valid;
	cfsd_pkg::cfsd_octet_t octet;

	modport ctrl (output sym_valid, output sym, output clr,
		input oct_valid, input octet);
	modport asm (input sym_valid, input sym, input clr,
		output oct_valid, output octet);
endinterface : cfsd_oct_if

/* verilog/cfsd_octet_asm.sv */
// Purpose: Pairs received symbols into octets, low symbol first
// Assumes: Symbols are synchronous single-cycle strobes
// Notes: Clear restarts pairing on the next symbol
`include "cfsd_defines.svh"

module cfsd_octet_asm (
	input wire logic core_clk,
	input wire logic rst_b,
	cfsd_oct_if.asm oi
);
	logic half_r;
	logic half_nxt;
	cfsd_pkg::cfsd_sym_t lo_r;
	cfsd_pkg::cfsd_sym_t lo_nxt;
	logic oct_valid_r;
	logic oct_valid_nxt;
	cfsd_pkg::cfsd_octet_t octet_r;
	cfsd_pkg::cfsd_octet_t octet_nxt;

	// ======================================================
	// Pairing
	always_comb begin
		half_nxt = half_r;
		lo_nxt = lo_r;
		oct_valid_nxt = 1'b0;
		octet_nxt = octet_r;
		if (oi.clr) begin
			half_nxt = 1'b0;
		end else if (oi.sym_valid) begin
			if (!half_r) begin
				lo_nxt = oi.sym;
				half_nxt = 1'b1;
			end else begin
				octet_nxt = {oi.sym, lo_r};
				oct_valid_nxt = 1'b1;
				half_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			half_r <= 1'b0;
			lo_r <= 4'h0;
			oct_valid_r <= 1'b0;
			octet_r <= 8'h00;
		end else begin
			half_r <= half_nxt;
			lo_r <= lo_nxt;
			oct_valid_r <= oct_valid_nxt;
			octet_r <= octet_nxt;
		end
	end

	assign oi.oct_valid = oct_valid_r;
	assign oi.octet = octet_r;

	a_octet_pair: assert property (@(posedge core_clk) disable iff (!rst_b)
		oct_valid_r |-> $past(half_r) && !$past(oi.clr))
		else $error("Octet produced without two symbols");
endmodule : cfsd_octet_asm

/* verification/cfsd_sym_src.sv */
// Purpose: Demodulated symbol source facing the delimiter detector
// Assumes: One symbol per strobe, low symbol of an octet first
// Notes: Idle data flips on each idle put so stale symbols never look valid
module cfsd_sym_src (
	input wire logic core_clk,
	output logic sync_hdr_found,
	output logic sym_valid,
	output logic [3:0] sym_data
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		sync_hdr_found = 1'h0;
		sym_valid = 1'h0;
		sym_data = 4'h5;
	end

	// ==========================================================
	// Symbol driving
	task automatic put(input logic s, input logic v, input logic [3:0] d);
		@(posedge core_clk);
		#1;
		sync_hdr_found = s;
		sym_valid = v;
		sym_data = v ? d : ~sym_data;
	endtask : put

	task automatic send_oct(input logic [7:0] o);
		put(1'h0, 1'h1, o[3:0]);
		put(1'h0, 1'h1, o[7:4]);
	endtask : send_oct
endmodule : cfsd_sym_src

/* verification/tb_configurable_sfd_detect.sv */
// Purpose: Self-checking bench for the frame delimiter detector
// Assumes: Symbols arrive back to back inside a frame
// Notes: Ordinary frames come from a table, odd cases follow it
`include "cfsd_defines.svh"

module tb_configurable_sfd_detect;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [7:0] d;
		logic [7:0] s;
		logic [6:0] l;
		logic en;
		logic [7:0] ei;
		logic [7:0] eb;
	} cfsd_row_t;

	logic core_clk, rst_b, reg_wr_en, rx_abort, rx_start_irq_en;
	logic sync_hdr_found, sym_valid, rx_start_irq, byte_aligned;
	logic rx_busy, fb_wr_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, fb_wr_data;
	logic [3:0] sym_data;
	logic [7:0] got [0:15];
	int n_errors, checked, n_got, n_irq, saw_al, saw_bz;
	// every delimiter keeps a nonzero low nibble
	cfsd_row_t rows [0:6] = '{
		'{8'ha7, 8'h57, 7'h02, 1'h1, 8'h00, 8'h00},
		'{8'ha7, 8'ha7, 7'h02, 1'h1, 8'h01, 8'h02},
		'{8'ha7, 8'h5a, 7'h02, 1'h1, 8'h00, 8'h00},
		'{8'ha7, 8'ha7, 7'h00, 1'h1, 8'h00, 8'h00},
		'{8'ha7, 8'ha7, 7'h02, 1'h0, 8'h00, 8'h02},
		'{8'h3c, 8'h3c, 7'h01, 1'h1, 8'h01, 8'h01},
		'{8'h3c, 8'ha7, 7'h01, 1'h1, 8'h00, 8'h00}};

	cfsd_top u_cfsd_top (.core_clk(core_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sync_hdr_found(sync_hdr_found),
		.sym_valid(sym_valid), .sym_data(sym_data), .rx_abort(rx_abort),
		.rx_start_irq_en(rx_start_irq_en), .rx_start_irq(rx_start_irq),
		.byte_aligned(byte_aligned), .rx_busy(rx_busy),
		.fb_wr_en(fb_wr_en), .fb_wr_data(fb_wr_data));
	cfsd_sym_src u_cfsd_sym_src (.core_clk(core_clk),
		.sync_hdr_found(sync_hdr_found), .sym_valid(sym_valid),
		.sym_data(sym_data));

	// ==========================================================
	// Clock, monitor and watchdog
	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (fb_wr_en === 1'h1 && n_got < 16) begin
			got[n_got] = fb_wr_data;
			n_got++;
		end
		if (rx_start_irq === 1'h1) n_irq++;
		if (byte_aligned === 1'h1) saw_al = 1;
		if (rx_busy === 1'h1) saw_bz = 1;
	end

	initial begin
		repeat (3000) @(posedge core_clk);
		n_errors++;
		finish_test();
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'h1;
		@(posedge core_clk);
		#1;
		reg_wr_en = 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		@(posedge core_clk);
		#1;
		check(reg_rdata, exp);
	endtask : rd

	function automatic logic [7:0] pay(input int i);
		return 8'h21 + 8'(i * 19);
	endfunction : pay

	task automatic frame(input logic [7:0] s, input logic [6:0] l,
		input bit ab, input int pre);
		n_got = 0;
		n_irq = 0;
		saw_al = 0;
		saw_bz = 0;
		u_cfsd_sym_src.put(1'h1, 1'h0, 4'h0);
		// Preamble zeros ahead of the delimiter are skipped while hunting
		repeat (pre) u_cfsd_sym_src.put(1'h0, 1'h1, `CFSD_PREAMBLE_SYM);
		u_cfsd_sym_src.send_oct(s);
		if (ab) begin
			// Let alignment happen first, then abort in the header
			u_cfsd_sym_src.put(1'h0, 1'h0, 4'h0);
			rx_abort = 1'h1;
			@(posedge core_clk);
			#1;
			rx_abort = 1'h0;
			check(8'(saw_al), 8'h01);
			saw_al = 0;
		end
		u_cfsd_sym_src.send_oct({1'h0, l});
		for (int i = 0; i < l; i++) u_cfsd_sym_src.send_oct(pay(i));
		repeat (4) u_cfsd_sym_src.put(1'h0, 1'h0, 4'h0);
	endtask : frame

	task automatic tally(input logic [7:0] ei, input logic [7:0] eb,
		input logic al);
		check(8'(n_irq), ei);
		check(8'(n_got), eb);
		check(8'(saw_al), {7'h00, al});
		check({7'h00, rx_busy}, 8'h00);
		check(8'(saw_bz), 8'h01);
		for (int i = 0; i < n_got; i++) check(got[i], pay(i));
	endtask : tally

	task automatic finish_test();
		$display("errors=%0d checks=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// ==========================================================
	// Main sequence
	initial begin
		rst_b = 1'h0;
		reg_addr = 8'h00;
		reg_wr_en = 1'h0;
		reg_wdata = 8'h00;
		rx_abort = 1'h0;
		rx_start_irq_en = 1'h1;
		repeat (4) @(posedge core_clk);
		#1;
		rst_b = 1'h1;
		rd(`CFSD_DELIM_OFS, `CFSD_DELIM_RST);
		wr(8'h0c, 8'h11);
		rd(8'h0c, 8'h00);
		rd(`CFSD_DELIM_OFS, `CFSD_DELIM_RST);
		wr(`CFSD_DELIM_OFS, 8'hf1);
		rd(`CFSD_DELIM_OFS, 8'hf1);
		foreach (rows[k]) begin
			wr(`CFSD_DELIM_OFS, rows[k].d);
			rx_start_irq_en = rows[k].en;
			frame(rows[k].s, rows[k].l, 1'b0, 0);
			tally(rows[k].ei, rows[k].eb, rows[k].d == rows[k].s);
		end
		// Abort right after alignment drops the frame
		wr(`CFSD_DELIM_OFS, 8'ha7);
		frame(8'ha7, 7'h02, 1'b1, 0);
		tally(8'h00, 8'h00, 1'h0);
		// A write landing during the hunt leaves that attempt alone
		fork
			frame(8'ha7, 7'h03, 1'b0, 4);
			begin
				repeat (2) @(posedge core_clk);
				wr(`CFSD_DELIM_OFS, 8'h5b);
			end
		join
		tally(8'h01, 8'h03, 1'h1);
		frame(8'ha7, 7'h01, 1'b0, 0);
		tally(8'h00, 8'h00, 1'h0);
		frame(8'h5b, 7'h01, 1'b0, 0);
		tally(8'h01, 8'h01, 1'h1);
		finish_test();
	end
endmodule : tb_configurable_sfd_detect
